// *** design/sdd_consts.svh ***
// Purpose: Shared constants for the sigma-delta decimation chain
// Assumes: Single 25 MHz master clock drives every register
// Notes: Filter coefficients are Q12 fixed point
`ifndef SDD_CONSTS_SVH
`define SDD_CONSTS_SVH

// Channel count: two voltage, two current, one temperature path
`define SDD_NCH 5

// Phase counter spans one output word period
`define SDD_CNT_W 10
`define SDD_SAMP_DIV 8
`define SDD_DEC_DIV 1024
`define SDD_SAMP_PH 3'h7
`define SDD_CNT_LAST 10'h3ff
`define SDD_CNT_ONE 10'h001
`define SDD_CNT_RST 10'h000

// Widened input levels for a one and a zero bit
`define SDD_BIT_POS 24'sh00_0001
`define SDD_BIT_NEG 24'shff_ffff
`define SDD_WORD_RST 24'sh00_0000

// Sinc3 over 128 input samples peaks at 128 cubed
`define SDD_SINC_MAX 24'sh20_0000

// Compensator: triple pole at z = -1/16, DC gain restored to one
`define SDD_IIR_GAIN 13'h1331
`define SDD_IIR_A1 13'h0300
`define SDD_IIR_A2 13'h0030
`define SDD_IIR_A3 13'h0001
`define SDD_IIR_Q 12

// Saturation limits of the 24-bit result
`define SDD_SAT_HI 40'sh00_007f_ffff
`define SDD_SAT_LO 40'shff_ff80_0000

`endif

// *** design/sdd_pkg.sv ***
// Purpose: Types for the sigma-delta decimation chain
// Assumes: Constants come from sdd_consts.svh
// Notes: Channel order fixes the routing of the modulator bits
package sdd_pkg;
  typedef logic signed [23:0] sdd_word_t;
  typedef logic signed [39:0] sdd_acc_t;
  typedef logic [9:0] sdd_phase_t;
  typedef logic [12:0] sdd_coef_t;
  typedef enum logic [2:0] {
    SDD_CH_V1 = 3'h0,
    SDD_CH_V2 = 3'h1,
    SDD_CH_I1 = 3'h2,
    SDD_CH_I2 = 3'h3,
    SDD_CH_TEMP = 3'h4
  } sdd_chan_t;
endpackage

// *** design/sdd_chan_if.sv ***
// Purpose: Link between the timing core and one sinc channel
// Assumes: Strobes are one clock wide
// Notes: The sinc word is held between decimation strobes
interface sdd_chan_if;
  import sdd_pkg::*;
  logic samp;
  logic decim;
  logic bit_in;
  sdd_word_t sinc;
  modport ctl (output samp, output decim, output bit_in, input sinc);
  modport flt (input samp, input decim, input bit_in, output sinc);
endinterface

// *** design/sdd_chan_filter.sv ***
// Purpose: Third-order sinc decimator for one modulator bitstream
// Assumes: samp every 8 clocks, decim on the last samp of 128
// Notes: Modular 24-bit wrap keeps the comb output exact
`include "sdd_consts.svh"

module sdd_chan_filter
  import sdd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Strobes and data to and from the timing core
  sdd_chan_if.flt ch
);

  sdd_word_t x_in;
  sdd_word_t int1_ff;
  sdd_word_t int2_ff;
  sdd_word_t int3_ff;
  sdd_word_t i3_dly_ff;
  sdd_word_t c1_dly_ff;
  sdd_word_t c2_dly_ff;
  sdd_word_t sinc_ff;
  sdd_word_t c1;
  sdd_word_t c2;
  sdd_word_t c3;

  // Bit one maps to +1, bit zero to -1
  assign x_in = ch.bit_in ? `SDD_BIT_POS : `SDD_BIT_NEG;

  // Pipelined integrators; wrap-around is harmless ahead of the combs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int1_ff <= `SDD_WORD_RST;
      int2_ff <= `SDD_WORD_RST;
      int3_ff <= `SDD_WORD_RST;
    end else if (ch.samp) begin
      int1_ff <= int1_ff + x_in;
      int2_ff <= int2_ff + int1_ff;
      int3_ff <= int3_ff + int2_ff;
    end
  end

  assign c1 = int3_ff - i3_dly_ff;
  assign c2 = c1 - c1_dly_ff;
  assign c3 = c2 - c2_dly_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      i3_dly_ff <= `SDD_WORD_RST;
      c1_dly_ff <= `SDD_WORD_RST;
      c2_dly_ff <= `SDD_WORD_RST;
      sinc_ff <= `SDD_WORD_RST;
    end else if (ch.decim) begin
      i3_dly_ff <= int3_ff;
      c1_dly_ff <= c1;
      c2_dly_ff <= c2;
      sinc_ff <= c3;
    end
  end

  assign ch.sinc = sinc_ff;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_widen_input: assert property (
    ch.samp |=> int1_ff == $past(int1_ff) + $past(x_in))
    else $error("integrator did not take the widened bit");

  a_sinc_range: assert property (
    ch.decim |=> (sinc_ff <= `SDD_SINC_MAX) && (sinc_ff >= -`SDD_SINC_MAX))
    else $error("sinc output outside the third-order range");

  a_sinc_hold: assert property (
    !ch.decim |=> $stable(sinc_ff))
    else $error("sinc output changed between decimation strobes");

endmodule

// *** design/sdd_decim_chain.sv ***
// Purpose: Five-channel sigma-delta decimation front end
// Assumes: Modulator bits are synchronous to clk and held 8 clocks
// Notes: Sinc3 by 128 then a third-order anti-droop compensator
//
// Notes on behaviour
// - Two current, two voltage paths; voltages share input
// - Each modulator feeds one single-bit stream
// - Take one bit per channel every eighth clock
// - Widen each bit to 24-bit signed
// - One word per channel every 1024 clocks
// - Third-order sinc, three integrators, three combs
// - Third-order IIR corrects sinc passband droop
`include "sdd_consts.svh"

module sdd_decim_chain
  import sdd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Modulator bitstreams
  input wire logic volt_bit,
  input wire logic cur1_bit,
  input wire logic cur2_bit,
  input wire logic temp_bit,
  // Compensated words at the output word rate
  output logic signed [23:0] v1_word,
  output logic signed [23:0] v2_word,
  output logic signed [23:0] i1_word,
  output logic signed [23:0] i2_word,
  output logic signed [23:0] temp_word,
  output logic word_valid
);

  // Coefficient product, widened so no term can overflow
  function automatic sdd_acc_t mul_k(input sdd_word_t v,
                                     input sdd_coef_t k);
    sdd_acc_t va;
    sdd_acc_t ka;
    va = sdd_acc_t'(v);
    ka = sdd_acc_t'({1'b0, k});
    mul_k = va * ka;
  endfunction

  // Clamp to 24 bits; the triple pole overshoots on full-scale steps
  function automatic sdd_word_t sat24(input sdd_acc_t a);
    if (a > `SDD_SAT_HI) begin
      sat24 = sdd_word_t'(`SDD_SAT_HI);
    end else if (a < `SDD_SAT_LO) begin
      sat24 = sdd_word_t'(`SDD_SAT_LO);
    end else begin
      sat24 = a[23:0];
    end
  endfunction

  sdd_phase_t cnt_ff;
  logic samp;
  logic decim;
  logic comp_go_ff;
  logic word_valid_ff;
  logic [`SDD_NCH-1:0] ch_bit;
  sdd_word_t comp_word [`SDD_NCH];

  // Output word period: 1024 clocks, input sample every 8th
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= `SDD_CNT_RST;
    end else begin
      cnt_ff <= cnt_ff + `SDD_CNT_ONE;
    end
  end

  assign samp = (cnt_ff[2:0] == `SDD_SAMP_PH);
  // Last of 128 samples closes the window, so decim implies samp
  assign decim = (cnt_ff == `SDD_CNT_LAST);

  // Sinc word lands one clock after decim, compensated one later
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      comp_go_ff <= 1'b0;
    end else begin
      comp_go_ff <= decim;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word_valid_ff <= 1'b0;
    end else begin
      word_valid_ff <= comp_go_ff;
    end
  end

  // Both voltage paths hang off the one voltage modulator
  assign ch_bit[SDD_CH_V1] = volt_bit;
  assign ch_bit[SDD_CH_V2] = volt_bit;
  assign ch_bit[SDD_CH_I1] = cur1_bit;
  assign ch_bit[SDD_CH_I2] = cur2_bit;
  assign ch_bit[SDD_CH_TEMP] = temp_bit;

  sdd_chan_if chan [`SDD_NCH] ();

  for (genvar g = 0; g < `SDD_NCH; g++) begin : g_ch
    sdd_word_t y1_ff;
    sdd_word_t y2_ff;
    sdd_word_t y3_ff;
    sdd_acc_t acc;

    assign chan[g].samp = samp;
    assign chan[g].decim = decim;
    assign chan[g].bit_in = ch_bit[g];

    sdd_chan_filter u_sinc (
      .clk (clk),
      .rst_n (rst_n),
      .ch (chan[g])
    );

    // Poles on the negative axis lift the band edge against sinc droop
    always_comb begin
      acc = mul_k(chan[g].sinc, `SDD_IIR_GAIN);
      acc = acc - mul_k(y1_ff, `SDD_IIR_A1);
      acc = acc - mul_k(y2_ff, `SDD_IIR_A2);
      acc = acc - mul_k(y3_ff, `SDD_IIR_A3);
      acc = acc >>> `SDD_IIR_Q;
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        y1_ff <= `SDD_WORD_RST;
        y2_ff <= `SDD_WORD_RST;
        y3_ff <= `SDD_WORD_RST;
      end else if (comp_go_ff) begin
        y1_ff <= sat24(acc);
        y2_ff <= y1_ff;
        y3_ff <= y2_ff;
      end
    end

    assign comp_word[g] = y1_ff;
  end

  // Every channel updates on the same clock, so one strobe serves all
  assign v1_word = comp_word[SDD_CH_V1];
  assign v2_word = comp_word[SDD_CH_V2];
  assign i1_word = comp_word[SDD_CH_I1];
  assign i2_word = comp_word[SDD_CH_I2];
  assign temp_word = comp_word[SDD_CH_TEMP];
  assign word_valid = word_valid_ff;

  // Helper: clocks since the previous decimation strobe, less one
  sdd_phase_t gap_ff;
  logic seen_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_ff <= `SDD_CNT_RST;
      seen_ff <= 1'b0;
    end else if (decim) begin
      gap_ff <= `SDD_CNT_RST;
      seen_ff <= 1'b1;
    end else begin
      gap_ff <= gap_ff + `SDD_CNT_ONE;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_samp_gap;
    (!samp) [*7] ##1 samp;
  endsequence

  sequence s_word_pipe;
    comp_go_ff ##1 word_valid_ff ##1 !word_valid_ff;
  endsequence

  a_volt_paths_match: assert property (
    comp_word[SDD_CH_V1] == comp_word[SDD_CH_V2])
    else $error("voltage paths diverged");

  a_bit_routing: assert property (
    chan[SDD_CH_V1].bit_in == volt_bit &&
    chan[SDD_CH_I1].bit_in == cur1_bit &&
    chan[SDD_CH_I2].bit_in == cur2_bit &&
    chan[SDD_CH_TEMP].bit_in == temp_bit)
    else $error("modulator bit routed to the wrong channel");

  a_samp_spacing: assert property (
    samp |=> s_samp_gap)
    else $error("input sample strobe not every eighth clock");

  a_decim_on_samp: assert property (
    decim |-> samp)
    else $error("decimation strobe off the sample grid");

  a_decim_period: assert property (
    decim && seen_ff |-> gap_ff == `SDD_CNT_LAST)
    else $error("output word period is not 1024 clocks");

  a_comp_hold: assert property (
    !comp_go_ff |=> $stable(comp_word[SDD_CH_I1]))
    else $error("compensator output moved without a sinc word");

  a_valid_timing: assert property (
    decim |=> s_word_pipe)
    else $error("valid strobe not two clocks after decimation");

  a_valid_cause: assert property (
    word_valid_ff |-> $past(decim, 2))
    else $error("valid strobe without a new word");

  // Words may only move on the edge that also raises the strobe
  a_words_hold: assert property (
    !comp_go_ff |=> $stable(comp_word[SDD_CH_V1]) &&
      $stable(comp_word[SDD_CH_I2]) && $stable(comp_word[SDD_CH_TEMP]))
    else $error("output word moved without the valid strobe");

  a_cnt_wrap: assert property (
    decim |=> cnt_ff == `SDD_CNT_RST)
    else $error("phase counter did not wrap after the last sample");

endmodule

// *** tb/sdd_mod_model.sv ***
// Purpose: Behavioural source of the four modulator bitstreams
// Assumes: Phase counter restarts with rst_n, as in the chain
// Notes: Pattern per stream: 0 low, 1 high, 2 alternating
module sdd_mod_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pattern select, two bits per stream, and off-phase upset
  input wire logic [7:0] mode,
  input wire logic glitch,
  // Bitstreams
  output logic volt_bit,
  output logic cur1_bit,
  output logic cur2_bit,
  output logic temp_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] cyc_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      cyc_ff <= 10'h000;
    else
      cyc_ff <= cyc_ff + 10'h001;
  end

  // Upset bits only away from the sample edge, to show they are ignored
  function automatic logic pick(input logic [1:0] m);
    logic v;
    v = (m == 2'h2) ? cyc_ff[3] : m[0];
    if (glitch && cyc_ff[2:0] != 3'h7)
      v = ~v;
    return v;
  endfunction

  // One bit per stream, one stream for both voltage paths
  always @(negedge clk) begin
    volt_bit <= pick(mode[1:0]);
    cur1_bit <= pick(mode[3:2]);
    cur2_bit <= pick(mode[5:4]);
    temp_bit <= pick(mode[7:6]);
  end
endmodule

// *** tb/tb.sv ***
// Purpose: Self-checking bench for the decimation chain
// Assumes: Inputs change on falling edges only
// Notes: Levels are judged after sinc and compensator settle
module tb
  import sdd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] mode = 8'h00;
  logic glitch = 1'b0;
  logic volt_bit, cur1_bit, cur2_bit, temp_bit;
  sdd_word_t v1_word, v2_word, i1_word, i2_word, temp_word;
  logic word_valid;
  int failures = 0;
  int checks = 0;

  sdd_mod_model mod_u (.clk(clk), .rst_n(rst_n), .mode(mode),
    .glitch(glitch), .volt_bit(volt_bit), .cur1_bit(cur1_bit),
    .cur2_bit(cur2_bit), .temp_bit(temp_bit));
  sdd_decim_chain dut_u (.clk(clk), .rst_n(rst_n), .volt_bit(volt_bit),
    .cur1_bit(cur1_bit), .cur2_bit(cur2_bit), .temp_bit(temp_bit),
    .v1_word(v1_word), .v2_word(v2_word), .i1_word(i1_word),
    .i2_word(i2_word), .temp_word(temp_word), .word_valid(word_valid));

  initial begin
    forever #20 clk = ~clk;
  end

  task automatic finish_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic err(input string msg);
    failures++;
    $display("[ERR] %0t %s", $time, msg);
  endtask

  task automatic chk_word(input sdd_word_t act, input sdd_word_t exp);
    checks++;
    if (act !== exp)
      err("word mismatch");
  endtask

  // Truncation in the compensator leaves a few counts of error
  task automatic chk_near(input sdd_word_t act, input int exp);
    checks++;
    if ($isunknown(act) || act > exp + 64 || act < exp - 64)
      err("level out of range");
  endtask

  task automatic chk_int(input int act, input int exp);
    checks++;
    if (act != exp)
      err("cycle count mismatch");
  endtask

  task automatic do_reset();
    rst_n = 1'b0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
  endtask

  task automatic wait_valid(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (word_valid !== 1'b1 && n < 2000);
    if (n >= 2000) begin
      err("no word_valid");
      finish_test();
    end
  endtask

  task automatic test_levels(input logic g);
    int n;
    mode = 8'h61;
    glitch = g;
    do_reset();
    repeat (8) wait_valid(n);
    chk_near(v1_word, 24'sh20_0000);
    chk_word(v2_word, v1_word);
    chk_near(i1_word, -24'sh20_0000);
    chk_near(i2_word, 24'sh00_0000);
    chk_near(temp_word, 24'sh20_0000);
    glitch = 1'b0;
    $display("levels test done, glitch %0b", g);
  endtask

  task automatic test_reset();
    int n;
    mode = 8'h55;
    do_reset();
    chk_word(v1_word, 24'sh00_0000);
    chk_word(temp_word, 24'sh00_0000);
    chk_word(i1_word, 24'sh00_0000);
    chk_word(i2_word, 24'sh00_0000);
    chk_word({23'h00_0000, word_valid}, 24'sh00_0000);
    wait_valid(n);
    chk_int(n, 1025);
    $display("reset test done");
  endtask

  task automatic test_timing();
    sdd_word_t prev;
    int n;
    mode = 8'h55;
    do_reset();
    wait_valid(n);
    repeat (3) begin
      prev = v1_word;
      n = 0;
      do begin
        @(negedge clk);
        n++;
        if (word_valid !== 1'b1)
          chk_word(v1_word, prev);
      end while (word_valid !== 1'b1 && n < 2000);
      chk_int(n, 1024);
    end
    $display("timing test done");
  endtask

  initial begin
    test_levels(1'b0);
    test_reset();
    test_timing();
    test_levels(1'b1);
    finish_test();
  end
endmodule
